// ==== apc_capability_regs.sv ====
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`include "apc_defines.svh"
// Function
// RULE_01: Header bits 23:20 read major revision 2
// RULE_02: Header bits 19:16 read minor revision 0
// RULE_03: Header next pointer bits 15:8 read zero
// RULE_04: Header bits 7:0 read capability ID 02h
// RULE_05: Status bits 31:24 report queue depth, default 1Fh
// RULE_06: Depth low bits follow control bits 12:10
// RULE_07: Status bit 9 reads one, sideband supported
// RULE_08: Status bit 5 reads zero, no high addressing
// RULE_09: Status bit 4 reads zero, no fast writes
// RULE_10: Status bits 2:0 rate flags, reset 111
// RULE_11: Override bit masks the 4x rate flag
// RULE_12: Rate applies to main and sideband bus
// RULE_13: Reset values 00200002h and 1F000207h
// RULE_14: Writes ignored, reserved bits read zero
module apc_capability_regs
  import apc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk, // 40 MHz configuration clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic [ADDR_W-1:0] addr, // Byte address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after rd
  output logic [5:0] request_queue_depth, // Queue depth in use
  output logic [2:0] ad_rate_cap, // Rate flags, main bus
  output logic [2:0] sba_rate_cap // Rate flags, sideband bus
);

  // Address decode, shared by the read and write paths
  function automatic apc_sel_t decode(input logic [ADDR_W-1:0] a);
    apc_sel_t s;
    s = APC_SEL_NONE;
    if (a == ADDR_W'(`APC_OFS_HEADER)) begin
      s = APC_SEL_HDR;
    end else if (a == ADDR_W'(`APC_OFS_STATUS)) begin
      s = APC_SEL_STAT;
    end else if (a == ADDR_W'(`APC_OFS_CTRL)) begin
      s = APC_SEL_CTRL;
    end
    return s;
  endfunction

  // Queue depth code to field value; illegal codes give the full depth
  function automatic logic [5:0] depth_val(input logic [2:0] code);
    logic [5:0] v;
    v = `APC_RQ_VAL_32;
    case (code)
      `APC_RQ_CODE_16: v = `APC_RQ_VAL_16;
      `APC_RQ_CODE_8: v = `APC_RQ_VAL_8;
      `APC_RQ_CODE_4: v = `APC_RQ_VAL_4;
      `APC_RQ_CODE_2: v = `APC_RQ_VAL_2;
      `APC_RQ_CODE_1: v = `APC_RQ_VAL_1;
      default: v = `APC_RQ_VAL_32;
    endcase
    return v;
  endfunction

  apc_sel_t rd_sel;
  apc_sel_t wr_sel;
  logic [2:0] ctrl_depth;
  logic ctrl_ovr;
  apc_word_t header;
  apc_word_t status;
  apc_word_t next_status;
  apc_word_t ctrl_word;
  apc_word_t next_rdata;

  assign rd_sel = decode(addr);
  assign wr_sel = decode(addr);

  // Header is fixed; reserved bits 31:24 read zero
  assign header = {8'h00, `APC_HDR_MAJOR, `APC_HDR_MINOR, // RULE_01 RULE_02
                   `APC_HDR_NEXT, `APC_HDR_CAPID}; // RULE_03 RULE_04

  // Port control register, the only writable state in the bank
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_depth <= `APC_RQ_CODE_32;
      ctrl_ovr <= 1'b0;
    end else if (wr && wr_sel == APC_SEL_CTRL) begin
      ctrl_depth <= wdata[`APC_CTRL_RQ_HI:`APC_CTRL_RQ_LO];
      ctrl_ovr <= wdata[`APC_CTRL_OVR_BIT];
    end
  end

  // Control word as read back; unused bits are zero
  always_comb begin
    ctrl_word = '0;
    ctrl_word[`APC_CTRL_RQ_HI:`APC_CTRL_RQ_LO] = ctrl_depth;
    ctrl_word[`APC_CTRL_OVR_BIT] = ctrl_ovr;
  end

  // Status word built from control; writes never reach it
  always_comb begin
    next_status = '0; // RULE_14
    next_status[`APC_RQ_HI:`APC_RQ_LO] = {2'b00, depth_val(ctrl_depth)}; // RULE_05 RULE_06
    next_status[`APC_SBA_BIT] = 1'b1; // RULE_07
    next_status[`APC_HIADDR_BIT] = 1'b0; // RULE_08
    next_status[`APC_FASTWR_BIT] = 1'b0; // RULE_09
    next_status[`APC_RATE_HI:`APC_RATE_LO] = `APC_RATE_ALL; // RULE_10
    next_status[`APC_RATE_4X] = !ctrl_ovr; // RULE_11
  end

  // Status held in flops so it shows the reset value from the start
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= `APC_STAT_RST; // RULE_13
    end else begin
      status <= next_status;
    end
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    next_rdata = '0;
    unique case (rd_sel)
      APC_SEL_HDR: next_rdata = header;
      APC_SEL_STAT: next_rdata = status;
      APC_SEL_CTRL: next_rdata = ctrl_word & `APC_CTRL_MASK;
      APC_SEL_NONE: next_rdata = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= '0;
    end
  end

  // Capability outputs; one rate value feeds both buses
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      request_queue_depth <= `APC_RQ_VAL_32;
      ad_rate_cap <= `APC_RATE_ALL;
      sba_rate_cap <= `APC_RATE_ALL;
    end else begin
      request_queue_depth <= next_status[`APC_RQ_OUT_HI:`APC_RQ_LO];
      ad_rate_cap <= next_status[`APC_RATE_HI:`APC_RATE_LO]; // RULE_12
      sba_rate_cap <= next_status[`APC_RATE_HI:`APC_RATE_LO]; // RULE_12
    end
  end

  // Helper: marks the first cycle after reset release
  logic seen_clk;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_clk <= 1'b0;
    end else begin
      seen_clk <= 1'b1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence hdr_read;
    rd && addr == ADDR_W'(`APC_OFS_HEADER);
  endsequence

  sequence stat_read;
    rd && addr == ADDR_W'(`APC_OFS_STATUS);
  endsequence

  chk_hdr_major: assert property (hdr_read |=> rdata[23:20] == `APC_HDR_MAJOR) // RULE_01
    else $error("header major revision wrong");
  chk_hdr_minor: assert property (hdr_read |=> rdata[19:16] == `APC_HDR_MINOR) // RULE_02
    else $error("header minor revision wrong");
  chk_hdr_next: assert property (hdr_read |=> rdata[15:8] == `APC_HDR_NEXT) // RULE_03
    else $error("header next pointer not zero");
  chk_hdr_capid: assert property (hdr_read |=> rdata == `APC_HDR_RST) // RULE_04
    else $error("header word or capability id wrong");

  chk_rq_default: assert property ( // RULE_05
    ctrl_depth == `APC_RQ_CODE_32 ##1 stat_read |=> rdata[31:24] == `APC_RQ_DEFAULT)
    else $error("default queue depth not 1Fh");

  chk_rq_mirror: assert property ( // RULE_06
    wr && addr == ADDR_W'(`APC_OFS_CTRL) ##1 !wr [*2]
    |-> request_queue_depth == depth_val($past(wdata[`APC_CTRL_RQ_HI:`APC_CTRL_RQ_LO], 2))
        && status[31:30] == 2'b00)
    else $error("queue depth does not follow control");

  chk_sba_flag: assert property (stat_read |=> rdata[9] && rdata[8:6] == 3'b000) // RULE_07
    else $error("sideband flag wrong");
  chk_hiaddr_flag: assert property (stat_read |=> !rdata[5]) // RULE_08
    else $error("high address flag set");
  chk_fastwr_flag: assert property (stat_read |=> !rdata[4] && !rdata[3]) // RULE_09
    else $error("fast write flag set");

  chk_rate_low: assert property (status[1:0] == 2'b11) // RULE_10
    else $error("1x or 2x rate flag cleared");

  chk_rate_ovr: assert property ( // RULE_11
    ctrl_ovr |=> !status[`APC_RATE_4X] && !ad_rate_cap[`APC_RATE_4X] && !sba_rate_cap[`APC_RATE_4X])
    else $error("4x flag not masked by override");

  chk_rate_both: assert property (ad_rate_cap == sba_rate_cap) // RULE_12
    else $error("bus rate flags differ");

  chk_reset_values: assert property ( // RULE_13
    !seen_clk |-> status == `APC_STAT_RST && header == `APC_HDR_RST)
    else $error("reset values wrong");

  chk_ro_write: assert property ( // RULE_14
    wr && (addr == ADDR_W'(`APC_OFS_HEADER) || addr == ADDR_W'(`APC_OFS_STATUS))
    |=> $stable(ctrl_depth) && $stable(ctrl_ovr) && status[23:10] == '0)
    else $error("write to read-only register had effect");

  chk_rd_unmapped: assert property (
    rd && decode(addr) == APC_SEL_NONE |=> rdata == '0)
    else $error("unmapped read not zero");

  chk_rd_only_once: assert property (!rd |=> rdata == '0)
    else $error("read data outside its cycle");

  // Depth field against fixed code values, independent of the decode function
  chk_rq_full: assert property ( // RULE_05
    ctrl_depth == `APC_RQ_CODE_32 |=> request_queue_depth == `APC_RQ_VAL_32)
    else $error("full queue depth not reported");

  chk_rq_half: assert property ( // RULE_06
    ctrl_depth == `APC_RQ_CODE_16 |=> request_queue_depth == `APC_RQ_VAL_16)
    else $error("half queue depth not reported");

  chk_rq_eight: assert property ( // RULE_06
    ctrl_depth == `APC_RQ_CODE_8 |=> request_queue_depth == `APC_RQ_VAL_8)
    else $error("eight deep queue not reported");

  chk_rq_one: assert property ( // RULE_06
    ctrl_depth == `APC_RQ_CODE_1 |=> request_queue_depth == `APC_RQ_VAL_1)
    else $error("single queue depth not reported");

  // Spare codes fall back to the deepest queue rather than an odd value
  chk_rq_spare: assert property ( // RULE_06
    ctrl_depth > `APC_RQ_CODE_1 |=> request_queue_depth == `APC_RQ_VAL_32)
    else $error("spare depth code not full depth");

  chk_rq_legal: assert property ( // RULE_06
    request_queue_depth inside {`APC_RQ_VAL_32, `APC_RQ_VAL_16, `APC_RQ_VAL_8,
                                `APC_RQ_VAL_4, `APC_RQ_VAL_2, `APC_RQ_VAL_1})
    else $error("queue depth not a selectable value");

  chk_rq_upper: assert property ( // RULE_06
    status[`APC_RQ_HI:`APC_RQ_OUT_HI+1] == 2'b00)
    else $error("queue depth upper bits not zero");

  // Status word and the capability outputs load together
  chk_rq_out: assert property ( // RULE_05
    status[`APC_RQ_OUT_HI:`APC_RQ_LO] == request_queue_depth)
    else $error("queue depth output differs from status");

  chk_rate_out: assert property ( // RULE_12
    ad_rate_cap == status[`APC_RATE_HI:`APC_RATE_LO])
    else $error("rate output differs from status");

  chk_stat_readback: assert property ( // RULE_05
    stat_read |=> rdata == $past(status))
    else $error("status read does not return status");

  chk_stat_fixed: assert property ( // RULE_07
    status[`APC_SBA_BIT] && !status[`APC_HIADDR_BIT] && !status[`APC_FASTWR_BIT])
    else $error("fixed status flags wrong");

  chk_rate_full: assert property ( // RULE_10
    !ctrl_ovr |=> status[`APC_RATE_HI:`APC_RATE_LO] == `APC_RATE_ALL && ad_rate_cap == `APC_RATE_ALL)
    else $error("rate flags not all set without override");

  chk_ovr_read: assert property ( // RULE_11
    ctrl_ovr ##1 stat_read |=> !rdata[`APC_RATE_4X] && rdata[1:0] == 2'b11)
    else $error("override not seen in status read");

  // Reserved places read zero and nothing but a control write moves state
  chk_hdr_reserved: assert property ( // RULE_14
    hdr_read |=> rdata[31:24] == 8'h00)
    else $error("header reserved bits not zero");

  chk_stat_reserved: assert property ( // RULE_14
    stat_read |=> rdata[23:10] == 14'h0000 && !rdata[3])
    else $error("status reserved bits not zero");

  chk_ctrl_hold: assert property ( // RULE_14
    !(wr && wr_sel == APC_SEL_CTRL) |=> $stable(ctrl_depth) && $stable(ctrl_ovr))
    else $error("control state moved without a control write");

  chk_wr_no_data: assert property ( // RULE_14
    wr |=> rdata == '0)
    else $error("write produced read data");

  // Main scenarios worth seeing in a run
  cov_hdr_read: cover property (hdr_read ##1 rdata == `APC_HDR_RST);
  cov_ovr_read: cover property (ctrl_ovr ##1 stat_read ##1 !rdata[2]);
  cov_depth_one: cover property (ctrl_depth == `APC_RQ_CODE_1 ##2 request_queue_depth == `APC_RQ_VAL_1);
  cov_back_to_back: cover property (stat_read ##1 hdr_read);
  cov_ovr_cleared: cover property ($fell(ctrl_ovr) ##2 ad_rate_cap[`APC_RATE_4X]);

endmodule

// ==== apc_capability_regs_tb_top.sv ====
`timescale 1ns/100ps
`include "apc_defines.svh"
module apc_capability_regs_tb_top
  import apc_pkg::*;
;
  logic clk;
  logic arst_n;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [5:0] request_queue_depth;
  logic [2:0] ad_rate_cap;
  logic [2:0] sba_rate_cap;
  int errors;
  int samples_checked;
  logic [31:0] d;

  apc_capability_regs #(.ADDR_W(8)) u_dut (
    .clk(clk),
    .arst_n(arst_n),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .request_queue_depth(request_queue_depth),
    .ad_rate_cap(ad_rate_cap),
    .sba_rate_cap(sba_rate_cap)
  );

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Depth code to field value; unused codes fall back to the deepest queue
  function automatic logic [5:0] exp_depth(input logic [2:0] c);
    case (c)
      `APC_RQ_CODE_16: exp_depth = `APC_RQ_VAL_16;
      `APC_RQ_CODE_8: exp_depth = `APC_RQ_VAL_8;
      `APC_RQ_CODE_4: exp_depth = `APC_RQ_VAL_4;
      `APC_RQ_CODE_2: exp_depth = `APC_RQ_VAL_2;
      `APC_RQ_CODE_1: exp_depth = `APC_RQ_VAL_1;
      default: exp_depth = `APC_RQ_VAL_32;
    endcase
  endfunction

  // Status word built field by field, reserved bits zero
  function automatic logic [31:0] exp_stat(input logic [2:0] c, input logic o);
    exp_stat = {2'b00, exp_depth(c), 14'h0000, 1'b1, 6'h00, ~o, 2'b11};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One bus cycle; strobes stay up until the next call so none is assigned twice in a step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dat);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wdata <= dat;
    @(posedge clk);
    #1;
  endtask

  task automatic idle();
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    bus(1'b0, a, 32'h0000_0000);
    check(name, rdata, exp);
  endtask

  task automatic chk_outs(input logic [2:0] c, input logic o);
    check("queue_depth", 32'(request_queue_depth), 32'(exp_depth(c)));
    check("ad_rate", 32'(ad_rate_cap), {29'h0, ~o, 2'b11});
    check("sba_rate", 32'(sba_rate_cap), {29'h0, ~o, 2'b11});
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog well beyond the roughly 140 cycles the sequence needs
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    complete_run();
  end

  initial begin
    arst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    void'($urandom(30844));
    repeat (3) @(posedge clk);
    #1;
    chk_outs(3'h0, 1'b0);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    rd_chk(`APC_OFS_HEADER, `APC_HDR_RST, "header");
    rd_chk(`APC_OFS_STATUS, `APC_STAT_RST, "status");
    idle();
    check("rdata_idle", rdata, 32'h0000_0000);
    // Writes to read-only and unmapped places must leave everything as it was
    bus(1'b1, `APC_OFS_HEADER, $urandom);
    bus(1'b1, `APC_OFS_STATUS, $urandom);
    bus(1'b1, 8'h10, $urandom);
    rd_chk(`APC_OFS_HEADER, `APC_HDR_RST, "header_wr");
    rd_chk(`APC_OFS_STATUS, `APC_STAT_RST, "status_wr");
    rd_chk(8'h10, 32'h0000_0000, "unmapped");
    // Every depth code first, all-ones word among them, then random settings
    for (int i = 0; i < 24; i++) begin
      d = $urandom;
      if (i < 8)
        d[12:10] = i[2:0];
      if (i == 7)
        d = 32'hFFFF_FFFF;
      bus(1'b1, `APC_OFS_CTRL, d);
      rd_chk(`APC_OFS_CTRL, d & `APC_CTRL_MASK, "control");
      rd_chk(`APC_OFS_STATUS, exp_stat(d[12:10], d[0]), "status_cfg");
      chk_outs(d[12:10], d[0]);
      bus(1'b1, `APC_OFS_STATUS, ~d);
      rd_chk(`APC_OFS_STATUS, exp_stat(d[12:10], d[0]), "status_ro");
    end
    // Reset in mid-run restores the defaults
    idle();
    arst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk_outs(3'h0, 1'b0);
    check("rdata_rst", rdata, 32'h0000_0000);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    rd_chk(`APC_OFS_CTRL, 32'h0000_0000, "control_rst");
    rd_chk(`APC_OFS_STATUS, `APC_STAT_RST, "status_rst");
    idle();
    complete_run();
  end
endmodule

// ==== apc_defines.svh ====
`ifndef APC_DEFINES_SVH
`define APC_DEFINES_SVH

// Register byte offsets
`define APC_OFS_HEADER 8'hA0
`define APC_OFS_STATUS 8'hA4
`define APC_OFS_CTRL 8'hB0

// Capability header fields
`define APC_HDR_MAJOR 4'h2
`define APC_HDR_MINOR 4'h0
`define APC_HDR_NEXT 8'h00
`define APC_HDR_CAPID 8'h02
`define APC_HDR_RST 32'h0020_0002

// Capability status fields and values
`define APC_RQ_HI 31
`define APC_RQ_LO 24
`define APC_RQ_DEFAULT 8'h1F
`define APC_SBA_BIT 9
`define APC_HIADDR_BIT 5
`define APC_FASTWR_BIT 4
`define APC_RATE_HI 2
`define APC_RATE_LO 0
`define APC_RATE_4X 2
`define APC_RATE_ALL 3'b111
`define APC_RQ_OUT_HI 29
`define APC_STAT_RST 32'h1F00_0207

// Port control register fields
`define APC_CTRL_RQ_HI 12
`define APC_CTRL_RQ_LO 10
`define APC_CTRL_OVR_BIT 0
`define APC_CTRL_MASK 32'h0000_1C01

// Request queue depth codes and field values
`define APC_RQ_CODE_32 3'h0
`define APC_RQ_CODE_16 3'h1
`define APC_RQ_CODE_8 3'h2
`define APC_RQ_CODE_4 3'h3
`define APC_RQ_CODE_2 3'h4
`define APC_RQ_CODE_1 3'h5
`define APC_RQ_VAL_32 6'h1F
`define APC_RQ_VAL_16 6'h0F
`define APC_RQ_VAL_8 6'h07
`define APC_RQ_VAL_4 6'h03
`define APC_RQ_VAL_2 6'h01
`define APC_RQ_VAL_1 6'h00

`endif

// ==== apc_pkg.sv ====
package apc_pkg;
  typedef logic [31:0] apc_word_t;
  typedef logic [2:0] apc_rate_t;
  // Register selected by a bus address
  typedef enum logic [1:0] {
    APC_SEL_NONE = 2'b00,
    APC_SEL_HDR = 2'b01,
    APC_SEL_STAT = 2'b10,
    APC_SEL_CTRL = 2'b11
  } apc_sel_t;
endpackage
